// >>> eoi_pkg.sv
// Register map, field positions and shared helpers of the E1 overhead inserter
package eoi_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INTL_ALIGN = 8'hd2;
    localparam logic [7:0] IDX_INTL_NONALIGN = 8'hd3;
    localparam logic [7:0] IDX_REMOTE_ALARM = 8'hd4;
    localparam logic [7:0] IDX_SPARE4 = 8'hd5;
    localparam logic [7:0] IDX_SPARE5 = 8'hd6;
    localparam logic [7:0] IDX_SPARE6 = 8'hd7;
    localparam logic [7:0] IDX_SPARE7 = 8'hd8;
    localparam logic [7:0] IDX_SPARE8 = 8'hd9;
    localparam logic [7:0] IDX_CONTROL = 8'hda;
    localparam logic [7:0] IDX_STATUS = 8'hdb;
    // Value of every register after reset
    localparam logic [7:0] REG_RESET = 8'h00;
    // Source numbers equal their enable bit in the control register
    localparam int SRC_SA8 = 0;
    localparam int SRC_SA7 = 1;
    localparam int SRC_SA6 = 2;
    localparam int SRC_SA5 = 3;
    localparam int SRC_SA4 = 4;
    localparam int SRC_RA = 5;
    localparam int SRC_INSERT_INTL_NONALIGN_ENABLE = 6;
    localparam int SRC_INSERT_INTL_ALIGN_ENABLE = 7;
    // Bit positions inside timeslot 0, bit 1 of the octet is index 0
    localparam logic [2:0] POS_SI = 3'h0;
    localparam logic [2:0] POS_RA = 3'h2;
    localparam logic [2:0] POS_SA4 = 3'h3;
    localparam logic [2:0] POS_SA5 = 3'h4;
    localparam logic [2:0] POS_SA6 = 3'h5;
    localparam logic [2:0] POS_SA7 = 3'h6;
    localparam logic [2:0] POS_SA8 = 3'h7;
    // Status register fields
    localparam int STAT_FRAME_LSB = 0;
    localparam int STAT_LOADED = 4;

    // Eight source bytes, indexed by source number
    typedef logic [7:0][7:0] eoi_bank_t;

    // Frame 15 or 14 lands on bit 0, frame 1 or 0 on bit 7
    function automatic logic [2:0] eoi_frame_slot(input logic [3:0] frameNum);
        return ~frameNum[3:1];
    endfunction
endpackage

// >>> eoi_snapshot.sv
// Multiframe-aligned snapshot of the source bytes and the enable byte
`timescale 1ns/1ns
module eoi_snapshot
    import eoi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire eoi_bank_t liveBank,
    input wire logic [7:0] liveCtrl,
    output eoi_bank_t shadowBank,
    output logic [7:0] shadowCtrl
);
    // Whole set taken in one edge, so a multiframe never mixes old and new
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shadowBank <= '0;
            shadowCtrl <= REG_RESET;
        end else if (load) begin
            shadowBank <= liveBank;
            shadowCtrl <= liveCtrl;
        end
    end

    // Between frame-0 starts the copy must not move
    shadowHold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !load |=> $stable(shadowBank) && $stable(shadowCtrl))
        else $error("snapshot changed outside multiframe start");
endmodule // eoi_snapshot

// >>> eoi_bit_pick.sv
// Decides whether a timeslot-0 bit is overwritten and with which value
`timescale 1ns/1ns
module eoi_bit_pick
    import eoi_pkg::*;
(
    input wire logic inTs0,
    input wire logic [3:0] frameNum,
    input wire logic [2:0] bitNum,
    input wire eoi_bank_t bank,
    input wire logic [7:0] ctrl,
    output logic hit,
    output logic value
);
    logic [2:0] slot; // Bit of the source byte for this frame
    logic [2:0] src; // Source serving this position
    logic srcValid; // Position is an overhead bit we own

    always_comb begin
        slot = eoi_frame_slot(frameNum);
        src = 3'h0;
        srcValid = 1'b0;
        if (inTs0) begin
            if (!frameNum[0]) begin
                // Align frame: only Si is free, the rest is the alignment word
                if (bitNum == POS_SI) begin
                    src = 3'(SRC_INSERT_INTL_ALIGN_ENABLE);
                    srcValid = 1'b1;
                end
            end else if (bitNum == POS_SI) begin
                src = 3'(SRC_INSERT_INTL_NONALIGN_ENABLE);
                srcValid = 1'b1;
            end else if (bitNum == POS_RA) begin
                src = 3'(SRC_RA);
                srcValid = 1'b1;
            end else if (bitNum >= POS_SA4) begin
                // Sa4..Sa8 at bits 4..8 map to sources 4..0
                src = 3'h7 - bitNum;
                srcValid = 1'b1;
            end
        end
        hit = srcValid && ctrl[src];
        value = bank[src][slot];
    end
endmodule // eoi_bit_pick

// >>> eoi_overhead_insert.sv
// E1 transmit overhead bit inserter with AHB-Lite register slave
`timescale 1ns/1ns
module eoi_overhead_insert
    import eoi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic txBitValid,
    input wire logic txBitIn,
    input wire logic txMfStart,
    input wire logic [3:0] txFrameNum,
    input wire logic txInTs0,
    input wire logic [2:0] txBitNum,
    output logic txBitOutValid,
    output logic txBitOut,
    output logic txBitInserted
);
    // Live registers written by software
    eoi_bank_t srcBank; // Source bytes by source number
    logic [7:0] ctrlReg; // Insertion enables
    // Copies used by the stream
    eoi_bank_t shadowBank;
    logic [7:0] shadowCtrl;
    // Values seen by the stream in this cycle
    eoi_bank_t effBank;
    logic [7:0] effCtrl;
    // Stream state shown in the status register
    logic [3:0] curFrame;
    logic snapLoaded;
    // Bus data phase bookkeeping
    logic dataPhaseWrite;
    logic [7:0] dataPhaseIdx;
    logic addrTaken;
    logic [7:0] busIdx;
    logic snapLoad;
    logic pickHit;
    logic pickValue;

    // Address phase accepted: selected, NONSEQ or SEQ, bus ready
    assign addrTaken = hsel && htrans[1] && hready;
    // Out-of-range or misaligned address decodes to index 0, unmapped
    // hsize is not decoded: only whole-word accesses are expected
    assign busIdx = (haddr[11:10] == 2'b00 && haddr[1:0] == 2'b00) ? haddr[9:2] : 8'h00;
    // Snapshot on the first timeslot-0 bit of frame 0
    // A frame-start flag without a valid bit is ignored on purpose
    assign snapLoad = txBitValid && txMfStart;

    // Registers that accept writes
    function automatic logic isWritable(input logic [7:0] idx);
        return idx >= IDX_INTL_ALIGN && idx <= IDX_CONTROL;
    endfunction

    // Source number of a source-byte register
    function automatic logic [2:0] srcOfIdx(input logic [7:0] idx);
        case (idx)
            IDX_INTL_ALIGN: return 3'(SRC_INSERT_INTL_ALIGN_ENABLE);
            IDX_INTL_NONALIGN: return 3'(SRC_INSERT_INTL_NONALIGN_ENABLE);
            IDX_REMOTE_ALARM: return 3'(SRC_RA);
            IDX_SPARE4: return 3'(SRC_SA4);
            IDX_SPARE5: return 3'(SRC_SA5);
            IDX_SPARE6: return 3'(SRC_SA6);
            IDX_SPARE7: return 3'(SRC_SA7);
            default: return 3'(SRC_SA8);
        endcase
    endfunction

    // Read value of one register, unmapped reads as zero
    function automatic logic [7:0] readValue(input logic [7:0] idx);
        logic [7:0] stat;
        stat = '0;
        stat[STAT_FRAME_LSB +: 4] = curFrame;
        stat[STAT_LOADED] = snapLoaded;
        if (idx == IDX_CONTROL) begin
            return ctrlReg;
        end else if (idx == IDX_STATUS) begin
            return stat;
        end else if (isWritable(idx)) begin
            return srcBank[srcOfIdx(idx)];
        end
        // Unmapped indices end here
        return 8'h00;
    endfunction

    // Data phase follows each accepted address phase
    // Only the index and the write flag are kept; write data arrives one cycle later
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dataPhaseWrite <= 1'b0;
            dataPhaseIdx <= 8'h00;
        end else begin
            dataPhaseWrite <= addrTaken && hwrite;
            if (addrTaken) begin
                dataPhaseIdx <= busIdx;
            end
        end
    end

    // Zero wait states, OKAY always; unmapped accesses are quietly absorbed
    // Kept as flip-flops so that every top output is registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data registered at the address phase edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata <= '0;
        end else if (addrTaken && !hwrite) begin
            // A write in its data phase to the same register is forwarded,
            // otherwise a back-to-back read would return the stale byte
            if (dataPhaseWrite && dataPhaseIdx == busIdx && isWritable(busIdx)) begin
                hrdata <= {24'h000000, hwdata[7:0]};
            end else begin
                hrdata <= {24'h000000, readValue(busIdx)};
            end
        end
    end

    // Software writes land in the live registers only
    // The stream sees them from the next frame 0 onwards
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            srcBank <= '0;
            ctrlReg <= REG_RESET;
        end else if (dataPhaseWrite && isWritable(dataPhaseIdx)) begin
            if (dataPhaseIdx == IDX_CONTROL) begin
                ctrlReg <= hwdata[7:0];
            end else begin
                srcBank[srcOfIdx(dataPhaseIdx)] <= hwdata[7:0];
            end
        end
    end

    // Copy of all sources, reloaded once per multiframe
    eoi_snapshot snapshot (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(snapLoad),
        .liveBank(srcBank),
        .liveCtrl(ctrlReg),
        .shadowBank(shadowBank),
        .shadowCtrl(shadowCtrl)
    );

    // Frame 0 bit uses the live set that the snapshot is taking now
    // A one-frame delay would avoid this mux but lose the frame-0 bit
    always_comb begin
        effBank = txMfStart ? srcBank : shadowBank;
        effCtrl = txMfStart ? ctrlReg : shadowCtrl;
    end

    // Position decode and source selection
    eoi_bit_pick picker (
        .inTs0(txInTs0),
        .frameNum(txFrameNum),
        .bitNum(txBitNum),
        .bank(effBank),
        .ctrl(effCtrl),
        .hit(pickHit),
        .value(pickValue)
    );

    // One-cycle stream stage; non-owned bits go through untouched
    // The output bit keeps its value between valid bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txBitOutValid <= 1'b0;
            txBitOut <= 1'b0;
            txBitInserted <= 1'b0;
        end else begin
            txBitOutValid <= txBitValid;
            if (txBitValid) begin
                txBitOut <= pickHit ? pickValue : txBitIn;
                txBitInserted <= pickHit;
            end
        end
    end

    // Stream position for software
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            curFrame <= 4'h0;
            snapLoaded <= 1'b0;
        end else begin
            if (txBitValid) begin
                curFrame <= txFrameNum;
            end
            if (snapLoad) begin
                snapLoaded <= 1'b1;
            end
        end
    end

    // Checks: expected bit of each source for the current frame
    // Registered once, so the checks see the one-cycle stream delay
    // A wrong slot or source in the picker shows up as a mismatch here
    logic [7:0] expBits;
    logic [7:0] expNow;
    logic ts0Odd;
    logic ts0Even;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            expNow[i] = effBank[i][eoi_frame_slot(txFrameNum)];
        end
    end
    assign ts0Odd = txBitValid && txInTs0 && txFrameNum[0];
    assign ts0Even = txBitValid && txInTs0 && !txFrameNum[0];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            expBits <= 8'h00;
        end else begin
            expBits <= expNow;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sa8Insert_a: assert property (
        ts0Odd && txBitNum == POS_SA8 && effCtrl[SRC_SA8]
        |=> txBitOut == expBits[SRC_SA8] && txBitInserted)
        else $error("Sa8 position not taken from its register");
    sa7Insert_a: assert property (
        ts0Odd && txBitNum == POS_SA7 && effCtrl[SRC_SA7]
        |=> txBitOut == expBits[SRC_SA7] && txBitInserted)
        else $error("Sa7 position not taken from its register");
    sa6Insert_a: assert property (
        ts0Odd && txBitNum == POS_SA6 && effCtrl[SRC_SA6]
        |=> txBitOut == expBits[SRC_SA6] && txBitInserted)
        else $error("Sa6 position not taken from its register");
    sa5Insert_a: assert property (
        ts0Odd && txBitNum == POS_SA5 && effCtrl[SRC_SA5]
        |=> txBitOut == expBits[SRC_SA5] && txBitInserted)
        else $error("Sa5 position not taken from its register");
    sa4Insert_a: assert property (
        ts0Odd && txBitNum == POS_SA4 && effCtrl[SRC_SA4]
        |=> txBitOut == expBits[SRC_SA4] && txBitInserted)
        else $error("Sa4 position not taken from its register");
    alarmInsert_a: assert property (
        ts0Odd && txBitNum == POS_RA && effCtrl[SRC_RA]
        |=> txBitOut == expBits[SRC_RA] && txBitInserted)
        else $error("remote alarm position not taken from its register");
    siNonalign_a: assert property (
        ts0Odd && txBitNum == POS_SI && effCtrl[SRC_INSERT_INTL_NONALIGN_ENABLE]
        |=> txBitOut == expBits[SRC_INSERT_INTL_NONALIGN_ENABLE] && txBitInserted)
        else $error("nonalign Si not taken from its register");
    siAlign_a: assert property (
        ts0Even && txBitNum == POS_SI && effCtrl[SRC_INSERT_INTL_ALIGN_ENABLE]
        |=> txBitOut == expBits[SRC_INSERT_INTL_ALIGN_ENABLE] && txBitInserted)
        else $error("align Si not taken from its register");
    disabledPass_a: assert property (
        txBitValid && (!txInTs0 || effCtrl == 8'h00)
        |=> txBitOutValid && txBitOut == $past(txBitIn) && !txBitInserted)
        else $error("untouched bit changed on its way through");
    alignWord_a: assert property (
        ts0Even && txBitNum != POS_SI |=> txBitOut == $past(txBitIn))
        else $error("alignment word bit overwritten");

    // Bus side: zero wait states, never an error response
    readyOkay_a: assert property (
        hreadyout && !hresp)
        else $error("bus slave stalled or answered with an error");

    // Control byte takes the low byte of the data phase
    ctrlWrite_a: assert property (
        dataPhaseWrite && dataPhaseIdx == IDX_CONTROL
        |=> {24'h000000, ctrlReg} == ($past(hwdata) & 32'h000000ff))
        else $error("control write did not land");
    // Sa4 byte lands in its own slot of the bank
    spareWrite_a: assert property (
        dataPhaseWrite && dataPhaseIdx == IDX_SPARE4
        |=> {24'h000000, srcBank[SRC_SA4]} == ($past(hwdata) & 32'h000000ff))
        else $error("Sa4 byte write did not land");
    // Align Si byte lands in its own slot of the bank
    alignWrite_a: assert property (
        dataPhaseWrite && dataPhaseIdx == IDX_INTL_ALIGN
        |=> {24'h000000, srcBank[SRC_INSERT_INTL_ALIGN_ENABLE]} == ($past(hwdata) & 32'h000000ff))
        else $error("align Si byte write did not land");
    // Reads decoded to index 0 (unmapped, misaligned or out of range) return zero
    unmappedRead_a: assert property (
        addrTaken && !hwrite && busIdx == 8'h00
        |=> hrdata == 32'h00000000)
        else $error("unmapped read returned data");
    // Read data stands until the next read is taken
    readHold_a: assert property (
        !(addrTaken && !hwrite) |=> $stable(hrdata))
        else $error("read data moved outside a read");

    // Stream side: one output bit per input bit, one cycle later
    outValid_a: assert property (
        txBitOutValid == $past(txBitValid))
        else $error("output valid does not follow input valid");
    // Output bit and inserted flag stand between valid bits; the output valid drops
    outHold_a: assert property (
        !txBitValid |=> $stable(txBitOut) && $stable(txBitInserted))
        else $error("output bit moved without an input bit");
    // Status shows the snapshot once taken, and the last frame
    loadedFlag_a: assert property (
        snapLoad |=> snapLoaded)
        else $error("snapshot flag not set");
    frameTrack_a: assert property (
        txBitValid |=> curFrame == $past(txFrameNum))
        else $error("status frame number not tracking the stream");

    // Scenarios worth seeing at least once in a run
    sa4Cover_c: cover property (ts0Odd && txBitNum == POS_SA4 && effCtrl[SRC_SA4] ##1 txBitInserted);
    siAlignCover_c: cover property (ts0Even && txBitNum == POS_SI && effCtrl[SRC_INSERT_INTL_ALIGN_ENABLE]);
    snapCover_c: cover property (snapLoad && ctrlReg != shadowCtrl);
    fwdCover_c: cover property (addrTaken && !hwrite && dataPhaseWrite && dataPhaseIdx == busIdx);
    ctrlCover_c: cover property (dataPhaseWrite && dataPhaseIdx == IDX_CONTROL);
endmodule // eoi_overhead_insert

// >>> e1_tx_overhead_bit_insert_bench.sv
// Self-checking bench of the E1 transmit overhead bit inserter
`timescale 1ns/1ns
module e1_tx_overhead_bit_insert_bench
    import eoi_pkg::*;
();
    localparam int LIMIT = 20000; // Cycle ceiling, well above the expected run
    logic refClk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic txBitValid = 1'b0;
    logic txBitIn = 1'b0;
    logic txMfStart = 1'b0;
    logic [3:0] txFrameNum = 4'h0;
    logic txInTs0 = 1'b0;
    logic [2:0] txBitNum = 3'h0;
    logic txBitOutValid;
    logic txBitOut;
    logic txBitInserted;
    logic [31:0] rngState = 32'd98162; // Fixed seed
    logic [31:0] expRd[$]; // Expected read data, oldest first
    logic [1:0] expBit[$]; // Expected {inserted, bit}
    eoi_bank_t liveBank = '0; // Model of the written sources
    eoi_bank_t shadowBank = '0; // Model of the frame-0 copy
    logic [7:0] liveCtrl = 8'h00;
    logic [7:0] shadowCtrl = 8'h00;
    logic [3:0] lastFrame = 4'h0;
    logic loaded = 1'b0;
    logic rdPhase = 1'b0; // Monitor saw a read address phase
    int failCount = 0;
    int nTests = 0;
    int cycles = 0;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    eoi_overhead_insert u_dut (
        .ref_clk(refClk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txBitValid(txBitValid), .txBitIn(txBitIn), .txMfStart(txMfStart),
        .txFrameNum(txFrameNum), .txInTs0(txInTs0), .txBitNum(txBitNum),
        .txBitOutValid(txBitOutValid), .txBitOut(txBitOut), .txBitInserted(txBitInserted)
    );

    // Clock at 20 ns period
    always #10 refClk = ~refClk;

    // Xorshift source of stimulus values
    function automatic logic [31:0] rnd();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    // Expected read value of one byte address
    function automatic logic [31:0] regVal(input logic [11:0] a);
        int s = int'(8'hd9) - int'(a[9:2]);
        if (a[11:10] != 2'b00 || a[1:0] != 2'b00) return 32'h0; // Unmapped
        if (a[9:2] == IDX_CONTROL) return {24'h0, liveCtrl};
        if (a[9:2] == IDX_STATUS) return {27'h0, loaded, lastFrame};
        if (s >= 0 && s <= 7) return {24'h0, liveBank[s]};
        return 32'h0;
    endfunction

    // Expected {inserted, bit} for one stream bit
    function automatic logic [1:0] expOut(input logic [3:0] fr, input logic ts0, input logic [2:0] bn,
                                          input logic inB, input eoi_bank_t bk, input logic [7:0] ct);
        int src = -1;
        logic [2:0] slot = 3'h7 - fr[3:1]; // Frame 1 or 0 on bit 7
        if (ts0 && !fr[0] && bn == POS_SI) src = SRC_INSERT_INTL_ALIGN_ENABLE; // Align frames, Si only
        if (ts0 && fr[0]) begin
            case (bn)
                POS_SI: src = SRC_INSERT_INTL_NONALIGN_ENABLE;
                POS_RA: src = SRC_RA;
                POS_SA4: src = SRC_SA4;
                POS_SA5: src = SRC_SA5;
                POS_SA6: src = SRC_SA6;
                POS_SA7: src = SRC_SA7;
                POS_SA8: src = SRC_SA8;
                default: src = -1;
            endcase
        end
        if (src >= 0 && ct[src]) return {1'b1, bk[src][slot]};
        return {1'b0, inB}; // Pass-through
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic completeRun();
        if (failCount == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Wait for ready sampled high at a rising edge
    task automatic waitReady();
        do begin
            @(posedge refClk);
        end while (hreadyout !== 1'b1);
    endtask

    // One single AHB-Lite transfer; model follows after the data phase
    task automatic busXfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
        int s = int'(8'hd9) - int'(a[9:2]);
        if (!wr) expRd.push_back(regVal(a));
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        if (wr && a[11:10] == 2'b00 && a[1:0] == 2'b00) begin
            if (a[9:2] == IDX_CONTROL) liveCtrl = d[7:0];
            else if (s >= 0 && s <= 7) liveBank[s] = d[7:0];
        end
    endtask

    // Rewrite all sources with random bytes and set the control byte
    task automatic loadAll(input logic [7:0] c);
        for (int s = 0; s < 8; s++) busXfer({2'b00, 8'hd9 - 8'(s), 2'b00}, 1'b1, rnd());
        busXfer({2'b00, IDX_CONTROL, 2'b00}, 1'b1, {24'(rnd() >> 8), c});
        busXfer({2'b00, IDX_CONTROL, 2'b00}, 1'b0, 32'h0); // Read right after write
        busXfer({2'b00, 8'hd2 + 8'(rnd() % 8), 2'b00}, 1'b0, 32'h0);
    endtask

    // One stream bit after a random idle gap
    task automatic sendBit(input logic [3:0] fr, input logic ts0, input logic [2:0] bn, input logic mfs);
        logic inB = 1'(rnd());
        repeat (rnd() % 3) begin
            txBitValid <= 1'b0;
            txBitNum <= 3'(rnd()); // Junk while not valid
            @(posedge refClk);
        end
        txBitValid <= 1'b1;
        txBitIn <= inB;
        txMfStart <= mfs;
        txFrameNum <= fr;
        txInTs0 <= ts0;
        txBitNum <= bn;
        // Start bit uses live values, later bits the frame-0 copy
        expBit.push_back(mfs ? expOut(fr, ts0, bn, inB, liveBank, liveCtrl)
                             : expOut(fr, ts0, bn, inB, shadowBank, shadowCtrl));
        if (mfs) begin
            shadowBank = liveBank;
            shadowCtrl = liveCtrl;
            loaded = 1'b1;
        end
        lastFrame = fr;
        @(posedge refClk);
    endtask

    // Frames lo..hi: whole timeslot 0 plus a few payload bits
    task automatic sendFrames(input int lo, input int hi);
        for (int f = lo; f <= hi; f++) begin
            for (int b = 0; b < 8; b++) sendBit(4'(f), 1'b1, 3'(b), f == 0 && b == 0);
            repeat (3) sendBit(4'(f), 1'b0, 3'(rnd()), 1'b0);
        end
        txBitValid <= 1'b0;
    endtask

    // Monitor: takes the oldest note whenever a result appears
    always @(posedge refClk) begin
        if (rdPhase) begin
            check(hrdata, expRd.size() ? expRd.pop_front() : 32'hdead);
            check({30'h0, hreadyout, hresp}, 32'h2);
        end
        if (txBitOutValid === 1'b1) begin
            check({30'h0, txBitInserted, txBitOut}, expBit.size() ? expBit.pop_front() : 32'hdead);
        end
        rdPhase <= hsel && htrans[1] && hready && !hwrite;
    end

    // Hang guard
    always @(posedge refClk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failCount++;
            completeRun();
        end
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge refClk);
        rst <= 1'b0;
        @(posedge refClk);
        for (int i = 'hd2; i <= 'hdb; i++) busXfer({2'b00, 8'(i), 2'b00}, 1'b0, 32'h0); // Reset values
        busXfer(12'h369, 1'b0, 32'h0); // Misaligned reads as zero
        busXfer(12'hf68, 1'b1, 32'hff); // Outside the map, ignored
        busXfer({2'b00, IDX_CONTROL, 2'b00}, 1'b0, 32'h0);
        for (int k = 0; k < 12; k++) begin
            // Each enable alone, then all, none and random
            loadAll(k < 8 ? 8'(1 << k) : k == 8 ? 8'hff : k == 9 ? 8'h00 : 8'(rnd()));
            sendFrames(0, 7);
            loadAll(8'(rnd())); // Mid-multiframe writes wait for frame 0
            sendFrames(8, 15);
        end
        busXfer({2'b00, IDX_STATUS, 2'b00}, 1'b1, 32'h0); // Read-only, ignored
        busXfer({2'b00, IDX_STATUS, 2'b00}, 1'b0, 32'h0);
        repeat (4) @(posedge refClk);
        check(32'(expBit.size() + expRd.size()), 32'h0);
        completeRun();
    end
endmodule // e1_tx_overhead_bit_insert_bench
